/* File: rtl/mposq_regs.svh */
`ifndef MPOSQ_REGS_SVH
`define MPOSQ_REGS_SVH
// ----------------------------------------
// timing constants
// ----------------------------------------
`define MPOSQ_CLK_HZ 20000000
`define MPOSQ_OFF_HOLD_MS 2000
`define MPOSQ_ON_HOLD_MS 5000
`define MPOSQ_HARD_HOLD_MS 200
`define MPOSQ_QUIET_MS 200
// hold times convert exactly at 20000 cycles per ms, with no rounding
`define MPOSQ_MS_CYC(ms) (((ms) * 20000) + 0)
`define MPOSQ_CNT_W 27
`endif

/* File: rtl/mposq_pkg.sv */
package mposq_pkg;
   typedef enum logic [2:0] {
      MPOSQ_OFF = 3'b000,
      MPOSQ_ON = 3'b001,
      MPOSQ_DETACH = 3'b010,
      MPOSQ_DOWN = 3'b011
   } mposq_dev_state_t;
   typedef enum logic [2:0] {
      MPOSQ_H_IDLE = 3'b000,
      MPOSQ_H_KEY = 3'b001,
      MPOSQ_H_WAIT = 3'b010,
      MPOSQ_H_HARD = 3'b011,
      MPOSQ_H_QUIET = 3'b100
   } mposq_host_state_t;
endpackage

/* File: rtl/mposq_link_if.sv */
`timescale 1ns/1ps
interface mposq_link_if;
   // open-drain power key and hard-off lines, pulled up inside the module
   logic power_key_oe;
   logic hard_off_oe;
   logic power_key_n;
   logic hard_off_n;
   logic power_good_out;
   assign power_key_n = ~power_key_oe;
   assign hard_off_n = ~hard_off_oe;
   modport dev (
      input power_key_n,
      input hard_off_n,
      output power_good_out
   );
   modport host (
      output power_key_oe,
      output hard_off_oe,
      input power_good_out
   );
endinterface

/* File: rtl/mposq_dev.sv */
`timescale 1ns/1ps
`include "mposq_regs.svh"
// Overview of operation
// - off by shutdown command or power key
// - host holds key low two seconds
// - shutdown starts only after key release
// - orderly off sends detach request first
// - power good falls once powered off
// - host holds hard-off low 200 ms
// - completed hard-off pulse forces off state
// - hard-off path skips network detach
// - host uses hard-off only when stuck
// - host always provides hard-off control
// - host keeps inputs low while off
// - host holds key low five seconds on
// - power good rises once powered on
// - host quiet on serial 200 ms
module mposq_dev
   import mposq_pkg::*;
#(
   // hold times in clock cycles; the defaults are the real timings at
   // 20 MHz, and a bench may shorten them so that a run stays short while
   // every decision is still taken on the same counters
   parameter int unsigned ON_HOLD = `MPOSQ_MS_CYC(`MPOSQ_ON_HOLD_MS),
   parameter int unsigned OFF_HOLD = `MPOSQ_MS_CYC(`MPOSQ_OFF_HOLD_MS),
   parameter int unsigned HARD_HOLD = `MPOSQ_MS_CYC(`MPOSQ_HARD_HOLD_MS)
)
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // link
   mposq_link_if.dev link,
   // network side
   input wire logic shutdown_command,
   output logic detach_req,
   input wire logic detach_done
);
   // limits compare in the counters' own width
   localparam logic [`MPOSQ_CNT_W-1:0] ON_CYC =
      `MPOSQ_CNT_W'(ON_HOLD);
   localparam logic [`MPOSQ_CNT_W-1:0] OFF_CYC =
      `MPOSQ_CNT_W'(OFF_HOLD);
   localparam logic [`MPOSQ_CNT_W-1:0] HARD_CYC =
      `MPOSQ_CNT_W'(HARD_HOLD);

   // ----------------------------------------
   // state decode
   // ----------------------------------------
   // any state but off keeps the supply up, detach included
   function automatic logic powered_f(input mposq_dev_state_t s);
      return (s != MPOSQ_OFF);
   endfunction

   // the network request stands for the whole detach state
   function automatic logic detaching_f(input mposq_dev_state_t s);
      return (s == MPOSQ_DETACH);
   endfunction

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   // both lines are asynchronous to ref_clk and idle high on their pull-ups;
   // bit 0 carries the power key, bit 1 the hard-off line
   wire [1:0] pin_n = {link.hard_off_n, link.power_key_n};
   wire [1:0] pin_sync;
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_sync
         logic [1:0] s_q;
         // reset to the idle level so no false release follows reset
         always_ff @(posedge ref_clk) begin
            if (!resetn) begin
               s_q <= 2'h3;
            end else begin
               s_q <= {s_q[0], pin_n[gi]};
            end
         end
         // nothing but the second stage may read the first
         assign pin_sync[gi] = s_q[1];
      end
   endgenerate

   wire key_low = ~pin_sync[0];
   wire hard_low = ~pin_sync[1];

   // ----------------------------------------
   // hold timers
   // ----------------------------------------
   logic [`MPOSQ_CNT_W-1:0] key_cnt_q;
   logic [`MPOSQ_CNT_W-1:0] hard_cnt_q;
   wire key_sat = (key_cnt_q == ON_CYC);
   wire hard_sat = (hard_cnt_q == HARD_CYC);
   // the counters saturate, so a very long press never wraps into a short one
   always_ff @(posedge ref_clk) begin
      if (!resetn || !key_low) begin
         key_cnt_q <= '0;
      end else if (!key_sat) begin
         key_cnt_q <= key_cnt_q + `MPOSQ_CNT_W'(1);
      end
   end

   // hard-off timer, same scheme
   always_ff @(posedge ref_clk) begin
      if (!resetn || !hard_low) begin
         hard_cnt_q <= '0;
      end else if (!hard_sat) begin
         hard_cnt_q <= hard_cnt_q + `MPOSQ_CNT_W'(1);
      end
   end

   // ----------------------------------------
   // release events
   // ----------------------------------------
   // one cycle after release the counter still holds the pulse length;
   // a press shorter than the limit leaves no event at all, and a press
   // that is still held never does
   wire key_rel = pin_sync[0] & (key_cnt_q != '0);
   wire on_pulse = key_rel & key_sat;
   wire off_pulse = key_rel & (key_cnt_q >= OFF_CYC);
   wire hard_done = pin_sync[1] & hard_sat;

   // ----------------------------------------
   // orderly off requests
   // ----------------------------------------
   mposq_dev_state_t st_q;
   mposq_dev_state_t st_d;
   // a command is only honoured while powered; one left high while off
   // must not start a detach on its own
   wire orderly_off = (shutdown_command | off_pulse) & powered_f(st_q);

   // ----------------------------------------
   // sequencer
   // ----------------------------------------
   always_comb begin
      st_d = st_q;
      case (st_q)
         MPOSQ_OFF: begin
            if (on_pulse) begin
               st_d = MPOSQ_ON;
            end
         end
         MPOSQ_ON: begin
            // the key is only acted on once released, never while low
            if (orderly_off) begin
               st_d = MPOSQ_DETACH;
            end
         end
         MPOSQ_DETACH: begin
            if (detach_done) begin
               st_d = MPOSQ_DOWN;
            end
         end
         MPOSQ_DOWN: begin
            // one cycle with the supply still up once the network has answered
            st_d = MPOSQ_OFF;
         end
         default: begin
            st_d = MPOSQ_OFF;
         end
      endcase
      // hard-off wins over everything and never asks for a detach
      if (hard_done) begin
         st_d = MPOSQ_OFF;
      end
   end

   // ----------------------------------------
   // state register
   // ----------------------------------------
   // reset lands in off: the module only comes up on a long key press
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         st_q <= MPOSQ_OFF;
      end else begin
         st_q <= st_d;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   logic pg_q;
   logic det_q;
   // registered from the next state: in step with st_q and glitch free,
   // at the cost of no extra latency
   wire pg_d = powered_f(st_d);
   wire det_d = detaching_f(st_d);
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         pg_q <= 1'b0;
      end else begin
         pg_q <= pg_d;
      end
   end
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         det_q <= 1'b0;
      end else begin
         det_q <= det_d;
      end
   end

   // ----------------------------------------
   // output wiring
   // ----------------------------------------
   assign link.power_good_out = pg_q;
   assign detach_req = det_q;
endmodule

/* File: rtl/mposq_host.sv */
`timescale 1ns/1ps
`include "mposq_regs.svh"
module mposq_host
   import mposq_pkg::*;
#(
   parameter int unsigned ON_CYC = `MPOSQ_MS_CYC(`MPOSQ_ON_HOLD_MS),
   parameter int unsigned OFF_CYC = `MPOSQ_MS_CYC(`MPOSQ_OFF_HOLD_MS),
   parameter int unsigned HARD_CYC = `MPOSQ_MS_CYC(`MPOSQ_HARD_HOLD_MS),
   parameter int unsigned QUIET_CYC = `MPOSQ_MS_CYC(`MPOSQ_QUIET_MS),
   parameter int unsigned WAIT_CYC = `MPOSQ_MS_CYC(`MPOSQ_ON_HOLD_MS)
)
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // link
   mposq_link_if.host link,
   // user requests, one-cycle pulses
   input wire logic power_on_req,
   input wire logic power_off_req,
   input wire logic emergency_req,
   // status
   output logic busy,
   output logic module_on,
   output logic serial_ok,
   output logic timeout_flag
);
   // ----------------------------------------
   // power good synchroniser
   // ----------------------------------------
   logic [1:0] pg_s_q;
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         pg_s_q <= 2'h0;
      end else begin
         pg_s_q <= {pg_s_q[0], link.power_good_out};
      end
   end
   wire pg = pg_s_q[1];

   // ----------------------------------------
   // sequencer
   // ----------------------------------------
   mposq_host_state_t st_q;
   mposq_host_state_t st_d;
   logic [`MPOSQ_CNT_W-1:0] cnt_q;
   logic [`MPOSQ_CNT_W-1:0] cnt_d;
   logic off_q;
   logic off_d;
   logic to_q;
   logic to_d;
   wire [`MPOSQ_CNT_W-1:0] cnt_inc = cnt_q + `MPOSQ_CNT_W'(1);
   wire [`MPOSQ_CNT_W-1:0] key_len =
      off_q ? `MPOSQ_CNT_W'(OFF_CYC) : `MPOSQ_CNT_W'(ON_CYC);
   always_comb begin
      st_d = st_q;
      cnt_d = cnt_inc;
      off_d = off_q;
      to_d = to_q;
      case (st_q)
         MPOSQ_H_IDLE: begin
            cnt_d = '0;
            // hard-off only on explicit emergency or a power-off wait timeout, never routinely
            if (emergency_req) begin
               st_d = MPOSQ_H_HARD;
            end else if (power_on_req && !pg) begin
               st_d = MPOSQ_H_KEY;
               off_d = 1'b0;
            end else if (power_off_req && pg) begin
               st_d = MPOSQ_H_KEY;
               off_d = 1'b1;
               to_d = 1'b0;
            end
         end
         MPOSQ_H_KEY: begin
            // hold two cycles past the minimum to cover synchroniser skew
            if (cnt_q > key_len) begin
               st_d = off_q ? MPOSQ_H_WAIT : MPOSQ_H_QUIET;
               cnt_d = '0;
            end
         end
         MPOSQ_H_WAIT: begin
            if (!pg) begin
               st_d = MPOSQ_H_IDLE;
            end else if (cnt_q == `MPOSQ_CNT_W'(WAIT_CYC)) begin
               st_d = MPOSQ_H_HARD;
               cnt_d = '0;
               to_d = 1'b1;
            end
         end
         MPOSQ_H_HARD: begin
            if (cnt_q > `MPOSQ_CNT_W'(HARD_CYC)) begin
               st_d = MPOSQ_H_IDLE;
            end
         end
         MPOSQ_H_QUIET: begin
            // quiet window counts from power good rising
            if (!pg) begin
               cnt_d = '0;
            end
            if (cnt_q == `MPOSQ_CNT_W'(QUIET_CYC)) begin
               st_d = MPOSQ_H_IDLE;
            end
         end
         default: begin
            st_d = MPOSQ_H_IDLE;
         end
      endcase
   end
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         st_q <= MPOSQ_H_IDLE;
         cnt_q <= '0;
         off_q <= 1'b0;
         to_q <= 1'b0;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         off_q <= off_d;
         to_q <= to_d;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign link.power_key_oe = (st_q == MPOSQ_H_KEY);
   assign link.hard_off_oe = (st_q == MPOSQ_H_HARD);
   assign busy = (st_q != MPOSQ_H_IDLE);
   assign module_on = pg;
   // serial traffic, and any high drive, only with module settled on
   assign serial_ok = pg && (st_q == MPOSQ_H_IDLE);
   assign timeout_flag = to_q;
endmodule

/* File: verification/mposq_assertions.sv */
`timescale 1ns/1ps
module mposq_assertions #(
   parameter int unsigned OFF_CYC = 20,
   parameter int unsigned HARD_CYC = 8
)
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // link
   input wire logic power_key_oe,
   input wire logic hard_off_oe,
   input wire logic power_key_n,
   input wire logic hard_off_n,
   input wire logic power_good_out,
   // network side
   input wire logic shutdown_command,
   input wire logic detach_req
);
   logic [31:0] key_lo_q;
   logic [31:0] hard_lo_q;
   always_ff @(posedge ref_clk) begin
      key_lo_q <= power_key_n ? 32'h0 : key_lo_q + 32'h1;
      hard_lo_q <= hard_off_n ? 32'h0 : hard_lo_q + 32'h1;
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   a_reset_pg_low: assert property (
      $rose(resetn) |-> !power_good_out && !detach_req)
      else $error("power good high after reset");
   a_pg_rise_rel: assert property (
      $rose(power_good_out) |-> power_key_n && hard_off_n)
      else $error("power good rose while a line is held");
   a_held_no_det: assert property (
      (!power_key_n && !shutdown_command) [*4] |-> !$rose(detach_req))
      else $error("detach began with key held");
   a_hard_no_det: assert property (
      (!hard_off_n) [*3] |-> !$rose(detach_req))
      else $error("detach during hard off");
   a_det_when_on: assert property (
      $rose(detach_req) |-> power_good_out)
      else $error("detach while off");
   a_key_off_det: assert property (
      $rose(power_key_n) && key_lo_q >= OFF_CYC && power_good_out
      && hard_off_n |-> ##[1:6] detach_req)
      else $error("no detach after off press");
   a_hard_forces: assert property (
      $rose(hard_off_n) && hard_lo_q >= HARD_CYC |-> ##[1:5] !power_good_out)
      else $error("still on after hard off");
   a_key_hold_len: assert property (
      $fell(power_key_oe) |-> key_lo_q >= OFF_CYC)
      else $error("key press too short");
   a_hard_hold_len: assert property (
      $fell(hard_off_oe) |-> hard_lo_q >= HARD_CYC)
      else $error("hard off press too short");
endmodule

/* File: verification/mposq_test.sv */
`timescale 1ns/1ps
module mposq_test;
   import mposq_pkg::*;
   localparam int ON_C = 50;
   localparam int OFF_C = 20;
   localparam int HARD_C = 8;
   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   logic shutdown_command = 1'b0;
   logic detach_done = 1'b0;
   logic power_on_req = 1'b0;
   logic power_off_req = 1'b0;
   logic emergency_req = 1'b0;
   logic detach_req, busy, module_on, serial_ok, timeout_flag;
   logic [31:0] rnd = 32'h0;
   integer seed = 32'h9D7C425D;
   int err_count = 0;
   int comparisons = 0;
   int k_run = 0;
   int h_run = 0;
   int m_on = 0;
   int m_det = 0;
   int settle = 0;
   logic cmd_go = 1'b0;
   int ops[6] = '{0, 1, 0, 2, 0, 3};
   int exp_q[$];
   mposq_link_if lk ();
   mposq_dev #(.ON_HOLD(ON_C), .OFF_HOLD(OFF_C), .HARD_HOLD(HARD_C))
      mposq_dev_inst (.ref_clk(ref_clk), .resetn(resetn), .link(lk),
      .shutdown_command(shutdown_command), .detach_req(detach_req),
      .detach_done(detach_done));
   mposq_host #(.ON_CYC(ON_C), .OFF_CYC(OFF_C), .HARD_CYC(HARD_C),
      .QUIET_CYC(8), .WAIT_CYC(100)) mposq_host_inst (.ref_clk(ref_clk),
      .resetn(resetn), .link(lk), .power_on_req(power_on_req),
      .power_off_req(power_off_req), .emergency_req(emergency_req),
      .busy(busy), .module_on(module_on), .serial_ok(serial_ok),
      .timeout_flag(timeout_flag));
   mposq_assertions #(.OFF_CYC(OFF_C), .HARD_CYC(HARD_C)) chk_inst (
      .ref_clk(ref_clk), .resetn(resetn), .power_key_oe(lk.power_key_oe),
      .hard_off_oe(lk.hard_off_oe), .power_key_n(lk.power_key_n),
      .hard_off_n(lk.hard_off_n), .power_good_out(lk.power_good_out),
      .shutdown_command(shutdown_command), .detach_req(detach_req));
   task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         $display("BAD %s exp %0h got %0h", nm, e, g);
         err_count++;
      end
   endtask
   task automatic wrap_up();
      if (err_count == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // ----
   // one host request, then a bounded wait for idle
   // ----
   task automatic req(input int op);
      int n;
      if (op == 3) cmd_go = 1'b1;
      #2;
      power_on_req = (op == 0);
      power_off_req = (op == 1);
      emergency_req = (op == 2);
      // the host only presses the key when the request fits the state
      if (op == 0 && module_on !== 1'b1) exp_q.push_back(ON_C);
      if (op == 1 && module_on === 1'b1) exp_q.push_back(OFF_C);
      @(posedge ref_clk);
      cmd_go = 1'b0;
      #2;
      power_on_req = 1'b0;
      power_off_req = 1'b0;
      emergency_req = 1'b0;
      n = 0;
      while ((busy !== 1'b0 || settle != 0 || m_det != 0) && n < 3000) begin
         @(posedge ref_clk);
         n++;
      end
      if (n == 3000) begin
         err_count++;
         wrap_up();
      end
      chk("module_on", m_on, module_on);
      if (op == 1) chk("timeout", 0, timeout_flag);
   endtask
   always #25 ref_clk = ~ref_clk;
   // stray commands only while settled off, where they must be ignored;
   // the network answers a pending detach after a random delay
   always @(posedge ref_clk) begin
      #2;
      rnd = $random(seed);
      shutdown_command = cmd_go | (rnd[0] & (m_on == 0) & (settle == 0));
      detach_done = detach_req & rnd[1];
   end
   // model: state changes open a settling window before pins are compared
   always @(negedge ref_clk) begin
      if (!resetn) begin
         k_run = 0;
         h_run = 0;
         m_on = 0;
         m_det = 0;
         settle = 0;
      end else begin
         if (settle > 0) begin
            settle--;
         end else begin
            chk("power_good", m_on, lk.power_good_out);
            if (!m_on) chk("detach_req", 0, detach_req);
            if (!m_on) chk("serial_ok", 0, serial_ok);
         end
         if (shutdown_command && m_on && !m_det) begin
            m_det = 1;
            settle = 8;
         end
         if (detach_done && m_det) begin
            m_on = 0;
            m_det = 0;
            settle = 8;
         end
         if (!lk.power_key_n) begin
            k_run++;
         end else if (k_run > 0) begin
            chk("key_hold", 1,
               exp_q.size() > 0 && k_run >= exp_q.pop_front());
            if (!m_on && k_run >= ON_C) begin
               m_on = 1;
            end else if (m_on && k_run >= OFF_C) begin
               m_det = 1;
            end
            settle = 8;
            k_run = 0;
         end
         if (!lk.hard_off_n) begin
            h_run++;
         end else if (h_run > 0) begin
            chk("hard_hold", 1, h_run >= HARD_C);
            if (h_run >= HARD_C) begin
               m_on = 0;
               m_det = 0;
            end
            settle = 8;
            h_run = 0;
         end
      end
   end
   initial begin
      repeat (2) @(posedge ref_clk);
      #2;
      resetn = 1'b1;
      @(negedge ref_clk);
      chk("busy", 0, busy);
      for (int i = 0; i < 10; i++) begin
         @(posedge ref_clk);
         req(i < 6 ? ops[i] : int'(rnd[5:4]));
      end
      wrap_up();
   end
endmodule
